// ==== hdl/acdms_params.svh ====
// Constants of the address decoder and memory select block
// Assumes inclusion by bare name from every design file that needs them
`ifndef ACDMS_PARAMS_SVH
`define ACDMS_PARAMS_SVH
// Register map, word indices on the slave bus (address bits 5:2)
`define ACD_REG_CTRL      4'h0
`define ACD_REG_STATUS    4'h1
`define ACD_REG_ROM_ADDR  4'h2
`define ACD_REG_ROM_DATA  4'h3
// Control register fields
`define ACD_CTRL_NOP      0
`define ACD_CTRL_SWAP     1
`define ACD_CTRL_RESET    2'h0
// Address regions on the processor bus
`define ACD_ROM_TOP       2'h3
`define ACD_IO_TOP        3'h1
`define ACD_LO_TOP        3'h0
// One kilobyte blocks inside the peripheral window
`define ACD_IO_BUS_IF     3'h0
`define ACD_IO_SIG_HALT   3'h1
`define ACD_IO_RD_CLR     3'h2
`define ACD_IO_RD_SET     3'h3
`define ACD_IO_STEP       3'h4
`define ACD_IO_FOUR_HALF  3'h5
`define ACD_IO_THREE_HALF 3'h6
`define ACD_IO_CONV_TRIGGER_STROBE       3'h7
// One kilobyte blocks inside the low window
`define ACD_LO_RAM        3'h0
`define ACD_LO_SWITCH     3'h1
`define ACD_LO_STATUS     3'h2
`define ACD_LO_PANEL      3'h3
`define ACD_LO_CAL        3'h6
`define ACD_LO_AUX        3'h7
// Phase level during which peripheral strobes may fire
`define ACD_STROBE_PHASE  1'b0
// Forced no-operation opcode
`define ACD_NOP_OPCODE    8'h01
// Supply settling time in microseconds and the clock rate
`define ACD_SETTLE_US     1000
`define ACD_CLK_MHZ       25
`define ACD_SETTLE_CYC    (`ACD_SETTLE_US * `ACD_CLK_MHZ)
`endif

// ==== hdl/acdms_pkg.sv ====
// Types shared by the decoder block
// Assumes the params header for numeric constants
package acdms_pkg;
   // Power-on sequencing states
   typedef enum logic [1:0] {
      ACDMS_PON_HOLD   = 2'b00,
      ACDMS_PON_SETTLE = 2'b01,
      ACDMS_PON_RUN    = 2'b10
   } acdms_pon_t;
endpackage

// ==== hdl/acdms_mem_if.sv ====
// Port bundle between the decoder and one memory array
// Assumes a single clock shared by both ends
`timescale 1ns/1ns
interface acdms_mem_if #(
   parameter int AW = 10,
   parameter int DW = 4
);
   logic [AW-1:0] addr;   // Word address
   logic          wr_en;  // One-cycle write strobe
   logic [DW-1:0] wdata;  // Write data
   logic [DW-1:0] rdata;  // Registered read data
   modport ctrl (output addr, output wr_en, output wdata, input rdata);
   modport mem  (input addr, input wr_en, input wdata, output rdata);
endinterface // acdms_mem_if

// ==== hdl/acdms_mem.sv ====
// Synchronous single-port memory with registered read data
// Assumes the controller holds the address one cycle before using data
`timescale 1ns/1ns
module acdms_mem #(
   parameter int AW = 10,
   parameter int DW = 4
) (
   input wire logic clk,
   acdms_mem_if.mem port
);
   logic [DW-1:0] store [0:(1<<AW)-1];  // Array contents
   logic [DW-1:0] rdata_reg;            // Read data register

   // Write on strobe, read every clock
   always_ff @(posedge clk) begin
      if (port.wr_en) begin
         store[port.addr] <= port.wdata;
      end
      rdata_reg <= store[port.addr];
   end

   assign port.rdata = rdata_reg;
endmodule // acdms_mem

// ==== hdl/acdms_decode.sv ====
// Address decoder, memory select, latches, data buffer control and power-on reset
// Assumes processor pins are asynchronous to clk and a slave bus on clk
`timescale 1ns/1ns
`include "acdms_params.svh"
module acdms_decode #(
   parameter int SETTLE_CYCLES = `ACD_SETTLE_CYC
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic [15:0] cpu_addr,
   input  wire logic        valid_access,
   input  wire logic        cpu_rw,
   input  wire logic        phase_clk,
   input  wire logic        power_good,
   input  wire logic [7:0]  cpu_data_in,
   output logic      [7:0]  cpu_data_out,
   output logic             cpu_data_oe,
   input  wire logic [7:0]  dev_data_in,
   output logic      [7:0]  dev_data_out,
   output logic             dev_data_oe,
   output logic             valid_access_buf_n,
   output logic             rom_bank_c_sel,
   output logic             rom_bank_d_sel,
   output logic             rom_bank_e_sel,
   output logic             rom_bank_f_sel,
   output logic             work_ram_sel_n,
   output logic             switch_buf_sel,
   output logic             status_buf_sel,
   output logic             front_panel_sel,
   output logic             cal_ram_sel,
   output logic             low_block_aux_sel,
   output logic             bus_iface_sel,
   output logic             sig_test_halt,
   output logic             conv_bit_step,
   output logic             conv_trigger_strobe,
   output logic             range_data,
   output logic             three_half_digits,
   output logic             system_reset_n
);
   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   localparam int PW = 36;
   logic [PW-1:0] pin_meta_reg;          // First stage, read only by second
   logic [PW-1:0] pin_sync_reg;          // Second stage
   logic          phase_dly_reg;         // Phase one cycle older
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_meta_reg  <= '0;
         pin_sync_reg  <= '0;
         phase_dly_reg <= 1'b0;
      end else begin
         pin_meta_reg  <= {dev_data_in, cpu_data_in, power_good, phase_clk, cpu_rw, valid_access, cpu_addr};
         pin_sync_reg  <= pin_meta_reg;
         phase_dly_reg <= pin_sync_reg[18];
      end
   end

   wire [15:0] a_s   = pin_sync_reg[15:0];   // Address
   wire        va_s  = pin_sync_reg[16];     // Valid access
   wire        rw_s  = pin_sync_reg[17];     // High on read
   wire        ph_s  = pin_sync_reg[18];     // Phase clock
   wire        pg_s  = pin_sync_reg[19];     // Supply good
   wire [7:0]  cd_s  = pin_sync_reg[27:20];  // Processor data
   wire [7:0]  dd_s  = pin_sync_reg[35:28];  // Device data

   ////////////////////////////////////////////////////////////////////////////////
   // Slave bus registers
   logic [1:0]  ctrl_reg;       // Test mode and digit swap
   logic [13:0] rom_addr_reg;   // Loader pointer
   logic [31:0] rdata_reg;      // Read answer
   logic        wait_reg;       // Waitrequest
   wire [3:0] reg_idx  = avs_address[5:2];
   wire       bus_req  = avs_read | avs_write;
   wire       bus_acc  = bus_req & ~wait_reg;                  // Completing edge
   wire       wr_acc   = avs_write & ~wait_reg;
   wire       nop_mode = ctrl_reg[`ACD_CTRL_NOP];
   wire       swap_dig = ctrl_reg[`ACD_CTRL_SWAP];
   wire       rom_load = wr_acc & (reg_idx == `ACD_REG_ROM_DATA);
   wire [31:0] rd_mux  = (reg_idx == `ACD_REG_CTRL)     ? {30'h0, ctrl_reg} :
                         (reg_idx == `ACD_REG_STATUS)   ? {28'h0, pg_s, system_reset_n, three_half_digits, range_data} :
                         (reg_idx == `ACD_REG_ROM_ADDR) ? {18'h0, rom_addr_reg} : 32'h0;

   // Bus handshake, one wait state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_reg     <= 1'b1;
         rdata_reg    <= 32'h0;
         ctrl_reg     <= `ACD_CTRL_RESET;
         rom_addr_reg <= 14'h0;
      end else begin
         wait_reg <= ~(bus_req & wait_reg);
         if (bus_req & wait_reg) begin
            rdata_reg <= rd_mux;
         end
         if (wr_acc & (reg_idx == `ACD_REG_CTRL)) begin
            ctrl_reg <= avs_writedata[1:0];
         end
         if (wr_acc & (reg_idx == `ACD_REG_ROM_ADDR)) begin
            rom_addr_reg <= avs_writedata[13:0];
         end else if (rom_load) begin
            rom_addr_reg <= rom_addr_reg + 14'h1;  // Auto increment
         end
      end
   end
   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Power-on sequencer
   acdms_pkg::acdms_pon_t pon_reg, pon_next;   // State
   logic [31:0] settle_reg;                     // Settling count
   logic        sys_rst_n_reg;                  // Reset output
   always_comb begin
      case (pon_reg)
         acdms_pkg::ACDMS_PON_HOLD:   pon_next = pg_s ? acdms_pkg::ACDMS_PON_SETTLE : acdms_pkg::ACDMS_PON_HOLD;
         acdms_pkg::ACDMS_PON_SETTLE: pon_next = !pg_s ? acdms_pkg::ACDMS_PON_HOLD :
                                      (settle_reg == 32'(SETTLE_CYCLES - 1)) ? acdms_pkg::ACDMS_PON_RUN :
                                      acdms_pkg::ACDMS_PON_SETTLE;
         acdms_pkg::ACDMS_PON_RUN:    pon_next = pg_s ? acdms_pkg::ACDMS_PON_RUN : acdms_pkg::ACDMS_PON_HOLD;
         default:                     pon_next = acdms_pkg::ACDMS_PON_HOLD;
      endcase
   end
   // Any supply dip restarts the settle wait
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pon_reg       <= acdms_pkg::ACDMS_PON_HOLD;
         settle_reg    <= 32'h0;
         sys_rst_n_reg <= 1'b0;
      end else begin
         pon_reg       <= pon_next;
         settle_reg    <= (pon_reg == acdms_pkg::ACDMS_PON_SETTLE) ? settle_reg + 32'h1 : 32'h0;
         sys_rst_n_reg <= (pon_next == acdms_pkg::ACDMS_PON_RUN);
      end
   end
   assign system_reset_n = sys_rst_n_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode from the six top bits, valid access and phase
   wire       rom_hit  = va_s & (a_s[15:14] == `ACD_ROM_TOP);
   wire       io_hit   = va_s & (a_s[15:13] == `ACD_IO_TOP) & (ph_s == `ACD_STROBE_PHASE);
   wire       lo_hit   = va_s & (a_s[15:13] == `ACD_LO_TOP);
   wire [2:0] blk      = a_s[12:10];
   wire [3:0] rom_dec  = {4{rom_hit}} & (4'h1 << a_s[13:12]);
   wire       ram_hit  = lo_hit & (blk == `ACD_LO_RAM);
   wire [2:0] set_3h   = swap_dig ? `ACD_IO_FOUR_HALF : `ACD_IO_THREE_HALF;
   wire [2:0] set_4h   = swap_dig ? `ACD_IO_THREE_HALF : `ACD_IO_FOUR_HALF;
   wire       ph_rise  = ph_s & ~phase_dly_reg;
   wire       ram_we   = ram_hit & ~rw_s & ph_rise;
   wire       mem_read = va_s & rw_s & (ram_hit | rom_hit);

   // Enable and strobe registers, undecoded space leaves all low
   logic [3:0] rom_sel_reg;       // Program ROM enables
   logic [5:0] lo_sel_reg;        // Low window enables
   logic [3:0] io_sel_reg;        // Peripheral strobes
   logic [1:0] latch_reg;         // Range and resolution levels
   logic       vab_n_reg;         // Buffered valid access
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rom_sel_reg <= 4'h0;
         lo_sel_reg  <= 6'h0;
         io_sel_reg  <= 4'h0;
         vab_n_reg   <= 1'b1;
      end else begin
         rom_sel_reg <= rom_dec;
         lo_sel_reg  <= {lo_hit & (blk == `ACD_LO_AUX), lo_hit & (blk == `ACD_LO_CAL),
                         lo_hit & (blk == `ACD_LO_PANEL), lo_hit & (blk == `ACD_LO_STATUS),
                         lo_hit & (blk == `ACD_LO_SWITCH), ram_hit};
         io_sel_reg  <= {io_hit & (blk == `ACD_IO_CONV_TRIGGER_STROBE), io_hit & (blk == `ACD_IO_STEP),
                         io_hit & (blk == `ACD_IO_SIG_HALT), io_hit & (blk == `ACD_IO_BUS_IF)};
         vab_n_reg   <= ~va_s;
      end
   end

   // Set/clear latches, cleared while the system is held in reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         latch_reg <= 2'h0;
      end else if (!sys_rst_n_reg) begin
         latch_reg <= 2'h0;
      end else begin
         if (io_hit & (blk == `ACD_IO_RD_SET)) latch_reg[0] <= 1'b1;
         else if (io_hit & (blk == `ACD_IO_RD_CLR)) latch_reg[0] <= 1'b0;
         if (io_hit & (blk == set_3h)) latch_reg[1] <= 1'b1;
         else if (io_hit & (blk == set_4h)) latch_reg[1] <= 1'b0;
      end
   end

   assign {rom_bank_f_sel, rom_bank_e_sel, rom_bank_d_sel, rom_bank_c_sel} = rom_sel_reg;
   assign work_ram_sel_n      = ~lo_sel_reg[0];
   assign switch_buf_sel      = lo_sel_reg[1];
   assign status_buf_sel      = lo_sel_reg[2];
   assign front_panel_sel     = lo_sel_reg[3];
   assign cal_ram_sel         = lo_sel_reg[4];
   assign low_block_aux_sel   = lo_sel_reg[5];
   assign bus_iface_sel       = io_sel_reg[0];
   assign sig_test_halt       = io_sel_reg[1];
   assign conv_bit_step       = io_sel_reg[2];
   assign conv_trigger_strobe = io_sel_reg[3];
   assign range_data          = latch_reg[0];
   assign three_half_digits   = latch_reg[1];
   assign valid_access_buf_n  = vab_n_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Memories: work RAM as two nibble arrays, program ROM loaded over the bus
   logic [7:0] ram_rdata;     // Joined nibbles
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_nib
         acdms_mem_if #(.AW(10), .DW(4)) nib_if ();
         assign nib_if.addr  = a_s[9:0];
         assign nib_if.wr_en = ram_we;
         assign nib_if.wdata = cd_s[gi*4 +: 4];
         assign ram_rdata[gi*4 +: 4] = nib_if.rdata;
         acdms_mem #(.AW(10), .DW(4)) u_nib (.clk(clk), .port(nib_if));
      end
   endgenerate
   acdms_mem_if #(.AW(14), .DW(8)) rom_if ();
   assign rom_if.addr  = rom_load ? rom_addr_reg : a_s[13:0];
   assign rom_if.wr_en = rom_load;
   assign rom_if.wdata = avs_writedata[7:0];
   acdms_mem #(.AW(14), .DW(8)) u_rom (.clk(clk), .port(rom_if));

   ////////////////////////////////////////////////////////////////////////////////
   // Data bus buffer and forced opcode source
   logic       ram_rd_reg, rom_rd_reg, dev_rd_reg;   // Read source one cycle old
   logic [7:0] cdo_reg, ddo_reg;                      // Data outputs
   logic       cdoe_reg, ddoe_reg;                    // Output enables
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ram_rd_reg <= 1'b0;
         rom_rd_reg <= 1'b0;
         dev_rd_reg <= 1'b0;
         cdo_reg    <= 8'h00;
         ddo_reg    <= 8'h00;
         cdoe_reg   <= 1'b0;
         ddoe_reg   <= 1'b0;
      end else begin
         ram_rd_reg <= va_s & rw_s & ram_hit;
         rom_rd_reg <= va_s & rw_s & rom_hit;
         dev_rd_reg <= va_s & rw_s & (lo_hit | io_hit) & ~ram_hit & ~mem_read;
         cdo_reg    <= nop_mode ? `ACD_NOP_OPCODE : rom_rd_reg ? rom_if.rdata :
                       ram_rd_reg ? ram_rdata : dd_s;
         cdoe_reg   <= nop_mode | ram_rd_reg | rom_rd_reg | dev_rd_reg;
         ddo_reg    <= cd_s;
         ddoe_reg   <= ~nop_mode & va_s & ~rw_s;
      end
   end
   assign cpu_data_out = cdo_reg;
   assign cpu_data_oe  = cdoe_reg;
   assign dev_data_out = ddo_reg;
   assign dev_data_oe  = ddoe_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   wire any_en = |rom_sel_reg | |lo_sel_reg | |io_sel_reg;
   a_enable_needs_valid: assert property (@(posedge clk) disable iff (!rst_b)
      any_en |-> $past(va_s)) else $error("Enable without valid access");
   a_rom_bank_map: assert property (@(posedge clk) disable iff (!rst_b)
      $past(va_s && a_s[15:12] == 4'hE) |-> rom_bank_e_sel && !rom_bank_c_sel && !rom_bank_f_sel)
      else $error("Wrong ROM bank");
   a_strobe_phase: assert property (@(posedge clk) disable iff (!rst_b)
      (conv_bit_step || conv_trigger_strobe) |-> $past(ph_s) == `ACD_STROBE_PHASE)
      else $error("Strobe outside phase");
   a_low_any_phase: assert property (@(posedge clk) disable iff (!rst_b)
      $past(va_s && a_s[15:10] == 6'h01) |-> switch_buf_sel) else $error("Switch enable missing");
   a_range_latch: assert property (@(posedge clk) disable iff (!rst_b)
      $past(sys_rst_n_reg && io_hit && blk == `ACD_IO_RD_SET) |-> range_data ##1 range_data)
      else $error("Range latch not set");
   a_bus_direction: assert property (@(posedge clk) disable iff (!rst_b)
      dev_data_oe |-> !cpu_data_oe || $past(nop_mode)) else $error("Both buffer directions driven");
   a_nop_opcode: assert property (@(posedge clk) disable iff (!rst_b)
      nop_mode ##1 nop_mode |=> cpu_data_oe && cpu_data_out == `ACD_NOP_OPCODE && !dev_data_oe)
      else $error("Forced opcode missing");
   a_ram_write_gate: assert property (@(posedge clk) disable iff (!rst_b)
      ram_we |-> !$past(ph_s) && va_s && !rw_s) else $error("RAM write outside phase");
   a_unmapped_quiet: assert property (@(posedge clk) disable iff (!rst_b)
      $past(a_s[15] != a_s[14]) |-> !any_en) else $error("Enable in unused range");
   a_reset_supply: assert property (@(posedge clk) disable iff (!rst_b)
      !pg_s |=> !system_reset_n [*2]) else $error("Reset released without supply");
   c_rom_read: cover property (@(posedge clk) disable iff (!rst_b) rom_rd_reg ##1 cpu_data_oe);
   c_ram_write: cover property (@(posedge clk) disable iff (!rst_b) ram_we);
   c_trigger: cover property (@(posedge clk) disable iff (!rst_b) conv_trigger_strobe);
   c_reset_release: cover property (@(posedge clk) disable iff (!rst_b) $rose(system_reset_n));
   // Buffer toward devices carries the write byte one clock after the synchronised pins
   a_dev_write_path: assert property (@(posedge clk) disable iff (!rst_b)
      $past(va_s && !rw_s && !nop_mode) |-> dev_data_oe && dev_data_out == $past(cd_s))
      else $error("Device buffer not driving write data");
   // Lowest block always selects the work RAM, whatever the phase
   a_ram_select_low: assert property (@(posedge clk) disable iff (!rst_b)
      $past(va_s && a_s[15:10] == 6'h00) |-> !work_ram_sel_n) else $error("RAM select missing");
   // Never more than one program ROM on the bus
   a_rom_one_hot: assert property (@(posedge clk) disable iff (!rst_b)
      $onehot0({rom_bank_c_sel, rom_bank_d_sel, rom_bank_e_sel, rom_bank_f_sel}))
      else $error("Several ROM banks enabled");
   // Exchanged digit blocks in use
   c_digit_swap: cover property (@(posedge clk) disable iff (!rst_b) swap_dig && three_half_digits);
endmodule // acdms_decode

// ==== verification/acdms_cpu_model.sv ====
// Processor bus model: address, direction, valid flag, phase clock, write data
// Assumes the bench clock; the block resynchronises every pin it drives
`timescale 1ns/1ns
module acdms_cpu_model (
   input  wire logic        clk,
   output logic      [15:0] cpu_addr,
   output logic             valid_access,
   output logic             cpu_rw,
   output logic             phase_clk,
   output logic      [7:0]  cpu_data_in
);
   // Idle bus at time zero
   initial begin
      cpu_addr = 16'h0000;
      valid_access = 1'b0;
      cpu_rw = 1'b1;
      phase_clk = 1'b0;
      cpu_data_in = 8'h00;
   end
   // Address half: phase low, address and direction presented
   task automatic addr_half(input logic [15:0] a, input logic rw, input logic v, input logic [7:0] d);
      @(posedge clk);
      cpu_addr <= a;
      valid_access <= v;
      cpu_rw <= rw;
      phase_clk <= 1'b0;
      cpu_data_in <= rw ? ~cpu_data_in : d; // Read: line released, shows inverse
      repeat (6) @(posedge clk);
   endtask
   // Data half: phase high marks the data bus valid
   task automatic data_half();
      @(posedge clk);
      phase_clk <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   // Release: valid drops, released lines show inverse of last value
   task automatic release_bus();
      @(posedge clk);
      phase_clk <= 1'b0;
      valid_access <= 1'b0;
      cpu_addr <= ~cpu_addr;
      cpu_data_in <= ~cpu_data_in;
      repeat (6) @(posedge clk);
   endtask
   // One whole bus cycle
   task automatic cycle(input logic [15:0] a, input logic rw, input logic v, input logic [7:0] d);
      addr_half(a, rw, v, d);
      data_half();
      release_bus();
   endtask
   // Serial result fetch: read one bit, then step to the next
   task automatic serial_fetch();
      for (int i = 0; i < 17; i++) begin
         cycle(16'h0800, 1'b1, 1'b1, 8'h00);
         cycle(16'h3000, 1'b1, 1'b1, 8'h00);
      end
   endtask
endmodule // acdms_cpu_model

// ==== verification/testbench.sv ====
// Self-checking bench for the address decoder block
// Assumes the design files and the processor model are compiled first
`timescale 1ns/1ns
module testbench;
   localparam int SETTLE = 16; // Shortened settling count
   logic        clk, rst_b, avs_read, avs_write, power_good, avs_waitrequest;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0]  dev_data_in, cpu_data_out, dev_data_out, cpu_data_in;
   logic [15:0] cpu_addr;
   logic        cpu_data_oe, dev_data_oe, valid_access_buf_n, valid_access, cpu_rw, phase_clk;
   logic        rom_bank_c_sel, rom_bank_d_sel, rom_bank_e_sel, rom_bank_f_sel, work_ram_sel_n, switch_buf_sel;
   logic        status_buf_sel, front_panel_sel, cal_ram_sel, low_block_aux_sel, bus_iface_sel, sig_test_halt;
   logic        conv_bit_step, conv_trigger_strobe, range_data, three_half_digits, system_reset_n;
   int          mismatches, cmp_count, step_rises;
   logic [13:0] sel_vec; // All enables and strobes, one bit each
   assign sel_vec = {rom_bank_c_sel, rom_bank_d_sel, rom_bank_e_sel, rom_bank_f_sel, ~work_ram_sel_n,
                     switch_buf_sel, status_buf_sel, front_panel_sel, cal_ram_sel, low_block_aux_sel,
                     bus_iface_sel, sig_test_halt, conv_bit_step, conv_trigger_strobe};
   // Clock, 40 ns period
   initial clk = 1'b0;
   always #20 clk = ~clk;
   // Counts step strobes seen
   always @(posedge conv_bit_step) step_rises++;
   acdms_cpu_model cpu_u (.clk, .cpu_addr, .valid_access, .cpu_rw, .phase_clk, .cpu_data_in);
   acdms_decode #(.SETTLE_CYCLES(SETTLE)) dut_u (
      .clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
      .cpu_addr, .valid_access, .cpu_rw, .phase_clk, .power_good, .cpu_data_in, .cpu_data_out, .cpu_data_oe,
      .dev_data_in, .dev_data_out, .dev_data_oe, .valid_access_buf_n, .rom_bank_c_sel, .rom_bank_d_sel,
      .rom_bank_e_sel, .rom_bank_f_sel, .work_ram_sel_n, .switch_buf_sel, .status_buf_sel, .front_panel_sel,
      .cal_ram_sel, .low_block_aux_sel, .bus_iface_sel, .sig_test_halt, .conv_bit_step, .conv_trigger_strobe,
      .range_data, .three_half_digits, .system_reset_n);
   ////////////////////////////////////////////////////////////
   // Value compare
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Register bus transfer, held until waitrequest seen low
   task automatic av_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask
   // Processor read with select, data and buffer direction checked
   task automatic rd_check(input logic [15:0] a, input logic [13:0] esel, input logic [7:0] ed);
      cpu_u.addr_half(a, 1'b1, 1'b1, 8'h00);
      chk("read select", esel, sel_vec);
      chk("read data", ed, cpu_data_out);
      chk("read buffer", 2'h2, {cpu_data_oe, dev_data_oe});
      chk("buffered valid", 1'b0, valid_access_buf_n);
      cpu_u.data_half();
      cpu_u.release_bus();
   endtask
   ////////////////////////////////////////////////////////////
   // Power-on hold and settling release
   task automatic t_reset();
      chk("reset held", 1'b0, system_reset_n);
      chk("enables idle", 14'h0000, sel_vec);
      power_good <= 1'b1;
      repeat (SETTLE - 4) @(posedge clk);
      chk("reset still held", 1'b0, system_reset_n);
      repeat (12) @(posedge clk);
      chk("reset released", 1'b1, system_reset_n);
   endtask
   // Load one byte per bank, read each back
   task automatic t_rom();
      for (int b = 0; b < 4; b++) begin
         av_xfer(1'b1, 6'h08, {18'h0, b[1:0], 12'h123});
         av_xfer(1'b1, 6'h0C, {24'h0, 6'h28, b[1:0]});
         av_xfer(1'b0, 6'h08, 32'h0);
         chk("loader pointer", {18'h0, b[1:0], 12'h124}, rd);
         rd_check({2'h3, b[1:0], 12'h123}, 14'h2000 >> b, {6'h28, b[1:0]});
      end
   endtask
   // Decode table with block edges, holes and invalid accesses
   task automatic t_decode();
      logic [15:0] adr [16] = '{16'h03FF, 16'h0400, 16'h0BFF, 16'h0C00, 16'h1800, 16'h1FFF, 16'h2000, 16'h27FF,
                                16'h33FF, 16'h3C00, 16'h13FF, 16'h1400, 16'h4000, 16'hBFFF, 16'h0000, 16'hC000};
      logic [13:0] exp [16] = '{14'h0200, 14'h0100, 14'h0080, 14'h0040, 14'h0020, 14'h0010, 14'h0008, 14'h0004,
                                14'h0002, 14'h0001, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h0000};
      for (int i = 0; i < 16; i++) begin
         cpu_u.addr_half(adr[i], 1'b1, i < 14, 8'h00);
         chk("decode phase low", exp[i], sel_vec);
         cpu_u.data_half();
         chk("decode phase high", exp[i] & 14'h3FF0, sel_vec);
         cpu_u.release_bus();
      end
   endtask
   // Set and clear both latches by access alone
   task automatic t_latch();
      logic [15:0] adr [4] = '{16'h2C00, 16'h2800, 16'h3BFF, 16'h3400};
      logic [1:0]  exp [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
      for (int i = 0; i < 4; i++) begin
         cpu_u.cycle(adr[i], i[0], 1'b1, 8'h00);
         chk("latch levels", exp[i], {three_half_digits, range_data});
         av_xfer(1'b0, 6'h04, 32'h0);
         chk("status word", {2'h3, exp[i]}, rd[3:0]);
      end
      av_xfer(1'b1, 6'h00, 32'h2);
      av_xfer(1'b0, 6'h00, 32'h0);
      chk("control word", 32'h2, rd);
      cpu_u.cycle(16'h3400, 1'b0, 1'b1, 8'h00);
      chk("swapped digits", 2'h2, {three_half_digits, range_data});
      av_xfer(1'b1, 6'h00, 32'h0);
   endtask
   // RAM writes, a refused invalid write, readback
   task automatic t_ram();
      cpu_u.addr_half(16'h0155, 1'b0, 1'b1, 8'hA5);
      chk("write buffer", 2'h1, {cpu_data_oe, dev_data_oe});
      chk("write data", 8'hA5, dev_data_out);
      cpu_u.data_half();
      cpu_u.release_bus();
      cpu_u.cycle(16'h03FF, 1'b0, 1'b1, 8'h3C);
      cpu_u.cycle(16'h0155, 1'b0, 1'b0, 8'hFF);
      rd_check(16'h0155, 14'h0200, 8'hA5);
      rd_check(16'h03FF, 14'h0200, 8'h3C);
   endtask
   // Device passthrough, forced opcode mode, unmapped register
   task automatic t_nop();
      dev_data_in <= 8'h96;
      rd_check(16'h0400, 14'h0100, 8'h96);
      av_xfer(1'b1, 6'h00, 32'h1);
      rd_check(16'h4000, 14'h0000, 8'h01);
      av_xfer(1'b1, 6'h00, 32'h0);
      av_xfer(1'b0, 6'h3C, 32'h0);
      chk("unmapped read", 32'h0, rd);
   endtask
   // Supply fault resets system and latches
   task automatic t_fault();
      cpu_u.cycle(16'h2C00, 1'b1, 1'b1, 8'h00);
      chk("fault latch set", 1'b1, range_data);
      power_good <= 1'b0;
      repeat (6) @(posedge clk);
      chk("fault reset", 2'h0, {system_reset_n, range_data});
      power_good <= 1'b1;
      repeat (SETTLE + 8) @(posedge clk);
      chk("fault recovery", 1'b1, system_reset_n);
   endtask
   ////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_b = 1'b0;
      power_good = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      dev_data_in = 8'h00;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      t_reset();
      t_rom();
      t_decode();
      t_latch();
      t_ram();
      t_nop();
      step_rises = 0;
      cpu_u.serial_fetch();
      chk("step strobes", 17, step_rises);
      t_fault();
      complete_run();
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      complete_run();
   end
endmodule // testbench
